// File: src/chc_cfg.svh
`ifndef CHC_CFG_SVH
`define CHC_CFG_SVH
`define CHC_CLK_PERIOD_NS 8
`define CHC_MS_NS 1000000
`define CHC_HOST_STATION 8'hFE
`define CHC_FUNC_HB 8'h1F
`define CHC_FUNC_TIMEOUT 8'h20
`define CHC_FUNC_PERIOD 8'h21
`define CHC_FUNC_PWRON 8'h60
`define CHC_FUNC_IO 8'h10
`define CHC_QUAL_ALL 8'h00
`define CHC_QUAL_OUT 8'h01
`define CHC_QUAL_IN 8'h02
`define CHC_HB_DATA 8'h00
`define CHC_DLC_BYTE 4'h1
`define CHC_DLC_PAIR 4'h2
`define CHC_DLC_WORD 4'h4
`define CHC_TIMEOUT_RST 32'h00000064
`define CHC_PERIOD_RST 32'h000003E8
`define CHC_MIN_MS 32'h0000000A
`define CHC_PWRON_RST 8'h00
`define CHC_SAFE_VALUE 8'h00
`define CHC_NV_TIMEOUT 2'h0
`define CHC_NV_PERIOD 2'h1
`define CHC_NV_PWRON 2'h2
`define CHC_HB_PERIOD_RST 32'h00000032
`define CHC_REG_CTRL 8'h00
`define CHC_REG_HB_PERIOD 8'h04
`define CHC_REG_CMD_HDR 8'h08
`define CHC_REG_CMD_LO 8'h0C
`define CHC_REG_CMD_HI 8'h10
`define CHC_REG_GO 8'h14
`define CHC_REG_STATUS 8'h18
`define CHC_REG_RESP_HDR 8'h1C
`define CHC_REG_RESP_LO 8'h20
`define CHC_REG_RESP_HI 8'h24
`define CHC_HDR_FUNC_LSB 0
`define CHC_HDR_STATION_LSB 8
`define CHC_HDR_QUAL_LSB 16
`define CHC_HDR_DLC_LSB 24
`define CHC_HDR_RTR_BIT 28
`define CHC_HDR_ACK_BIT 29
`define CHC_CTRL_HB_EN_BIT 0
`define CHC_STAT_BUSY_BIT 0
`define CHC_STAT_RESP_BIT 1
`endif

// File: src/chc_pkg.sv
package chc_pkg;
  typedef struct packed {
    logic ack;
    logic [7:0] func;
    logic [7:0] station;
    logic [7:0] qual;
    logic rtr;
    logic [3:0] dlc;
    logic [63:0] data;
  } chc_frame_s;

  typedef enum logic [1:0] {
    CHC_TX_IDLE = 2'b01,
    CHC_TX_BUSY = 2'b10
  } chc_tx_e;
endpackage

// File: src/chc_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface chc_link_if;
  logic m2s_valid;
  chc_pkg::chc_frame_s m2s_frame;
  logic s2m_valid;
  logic s2m_ready;
  chc_pkg::chc_frame_s s2m_frame;

  modport dev (input m2s_valid, input m2s_frame, input s2m_ready, output s2m_valid, output s2m_frame);
  modport host (output m2s_valid, output m2s_frame, output s2m_ready, input s2m_valid, input s2m_frame);
endinterface
`default_nettype wire

// File: src/chc_device.sv
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "chc_cfg.svh"
module chc_device #(
  parameter int unsigned CYC_PER_MS = `CHC_MS_NS / `CHC_CLK_PERIOD_NS
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  chc_link_if.dev link,
  input wire logic [7:0] i_station_number,
  input wire logic [7:0] i_input_lines,
  input wire logic i_out_cmd_valid,
  input wire logic [7:0] i_out_cmd_value,
  input wire logic [7:0] i_nv_power_on_value,
  output logic [7:0] o_output_lines,
  output logic o_safe_mode,
  output logic o_nv_write,
  output logic [1:0] o_nv_sel,
  output logic [31:0] o_nv_data
);
  logic booted;
  logic [31:0] ms_cnt;
  logic [31:0] hb_ms;
  logic [31:0] timeout;
  logic [31:0] period;
  logic [7:0] rep_mode;
  logic [31:0] rep_ms;
  logic rep_pend;
  logic [7:0] out_value;
  logic [7:0] pwr_stored;
  logic safe;
  chc_pkg::chc_tx_e tx_state;
  chc_pkg::chc_frame_s tx_frame;

  logic next_booted;
  logic [31:0] next_ms_cnt;
  logic [31:0] next_hb_ms;
  logic [31:0] next_timeout;
  logic [31:0] next_period;
  logic [7:0] next_rep_mode;
  logic [31:0] next_rep_ms;
  logic next_rep_pend;
  logic [7:0] next_out_value;
  logic [7:0] next_pwr_stored;
  logic next_safe;
  chc_pkg::chc_tx_e next_tx_state;
  chc_pkg::chc_frame_s next_tx_frame;
  logic [7:0] next_output_lines;
  logic next_nv_write;
  logic [1:0] next_nv_sel;
  logic [31:0] next_nv_data;

  chc_pkg::chc_frame_s rx;
  chc_pkg::chc_frame_s resp;
  logic [31:0] rx_word;
  logic tick;
  logic hb_seen;
  logic mine;
  logic send_resp;

  assign link.s2m_valid = (tx_state == chc_pkg::CHC_TX_BUSY);
  assign link.s2m_frame = tx_frame;

  always_comb begin
    rx = link.m2s_frame;
    rx_word = rx.data[31:0];
    tick = (ms_cnt == 32'(CYC_PER_MS - 1));
    next_booted = 1'b1;
    next_ms_cnt = tick ? 32'h00000000 : ms_cnt + 32'h00000001;
    next_hb_ms = hb_ms;
    next_timeout = timeout;
    next_period = period;
    next_rep_mode = rep_mode;
    next_rep_ms = rep_ms;
    next_rep_pend = rep_pend;
    next_out_value = out_value;
    next_pwr_stored = pwr_stored;
    next_safe = safe;
    next_tx_state = tx_state;
    next_tx_frame = tx_frame;
    next_nv_write = 1'b0;
    next_nv_sel = o_nv_sel;
    next_nv_data = o_nv_data;
    send_resp = 1'b0;
    resp = rx;
    resp.ack = 1'b1;

    // power-on value is read from nonvolatile store once, at boot
    if (!booted) begin
      next_out_value = i_nv_power_on_value;
      next_pwr_stored = i_nv_power_on_value;
    end else if (i_out_cmd_valid && !safe) begin
      next_out_value = i_out_cmd_value;
    end

    // heartbeat supervision; counter saturates at the timeout
    hb_seen = link.m2s_valid && !rx.ack && rx.station == `CHC_HOST_STATION && rx.func == `CHC_FUNC_HB &&
              rx.qual == `CHC_QUAL_ALL && !rx.rtr && rx.dlc == `CHC_DLC_BYTE &&
              rx.data[7:0] == `CHC_HB_DATA;
    if (hb_seen) begin
      next_hb_ms = 32'h00000000;
      next_safe = 1'b0;
    end else if (tick && hb_ms < timeout) begin
      next_hb_ms = hb_ms + 32'h00000001;
    end
    if (!hb_seen && next_hb_ms >= timeout) begin
      next_safe = 1'b1;
    end

    // automatic status report timer
    if (period == 32'h00000000) begin
      next_rep_ms = 32'h00000000;
      next_rep_pend = 1'b0;
    end else if (tick) begin
      if (rep_ms + 32'h00000001 >= period) begin
        next_rep_ms = 32'h00000000;
        next_rep_pend = 1'b1;
      end else begin
        next_rep_ms = rep_ms + 32'h00000001;
      end
    end

    // commands are only taken while the transmitter is free; the far end sees no answer otherwise
    mine = link.m2s_valid && !rx.ack && rx.station == i_station_number &&
           tx_state == chc_pkg::CHC_TX_IDLE;
    if (mine) begin
      case (rx.func)
        `CHC_FUNC_TIMEOUT: begin
          if (rx.rtr && rx.dlc == `CHC_DLC_WORD) begin
            resp.rtr = 1'b0;
            resp.data = {32'h00000000, timeout};
            send_resp = 1'b1;
          end else if (!rx.rtr && rx.dlc == `CHC_DLC_WORD && rx.qual == `CHC_QUAL_ALL &&
                       rx_word >= `CHC_MIN_MS) begin
            next_timeout = rx_word;
            next_hb_ms = 32'h00000000;
            next_nv_write = 1'b1;
            next_nv_sel = `CHC_NV_TIMEOUT;
            next_nv_data = rx_word;
            send_resp = 1'b1;
          end
        end
        `CHC_FUNC_PERIOD: begin
          if (rx.rtr && rx.dlc == `CHC_DLC_WORD) begin
            resp.rtr = 1'b0;
            resp.data = {32'h00000000, period};
            send_resp = 1'b1;
          end else if (!rx.rtr && rx.dlc == `CHC_DLC_WORD && rx.qual <= `CHC_QUAL_IN &&
                       (rx_word == 32'h00000000 || rx_word >= `CHC_MIN_MS)) begin
            next_period = rx_word;
            next_rep_mode = rx.qual;
            next_rep_ms = 32'h00000000;
            next_rep_pend = 1'b0;
            next_nv_write = 1'b1;
            next_nv_sel = `CHC_NV_PERIOD;
            next_nv_data = rx_word;
            send_resp = 1'b1;
          end
        end
        `CHC_FUNC_PWRON: begin
          if (rx.qual == `CHC_QUAL_OUT && rx.dlc == `CHC_DLC_BYTE) begin
            if (rx.rtr) begin
              resp.rtr = 1'b0;
              resp.data = {56'h00000000000000, pwr_stored};
            end else begin
              // outputs keep their present value until the next power cycle
              next_pwr_stored = rx.data[7:0];
              next_nv_write = 1'b1;
              next_nv_sel = `CHC_NV_PWRON;
              next_nv_data = {24'h000000, rx.data[7:0]};
            end
            send_resp = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // transmitter: command answers go ahead of a waiting report
    case (tx_state)
      chc_pkg::CHC_TX_IDLE: begin
        if (send_resp) begin
          next_tx_frame = resp;
          next_tx_state = chc_pkg::CHC_TX_BUSY;
        end else if (rep_pend && period != 32'h00000000) begin
          next_tx_frame.ack = 1'b1;
          next_tx_frame.func = `CHC_FUNC_IO;
          next_tx_frame.station = i_station_number;
          next_tx_frame.qual = rep_mode;
          next_tx_frame.rtr = 1'b0;
          next_tx_frame.dlc = (rep_mode == `CHC_QUAL_ALL) ? `CHC_DLC_PAIR : `CHC_DLC_BYTE;
          next_tx_frame.data = {48'h000000000000, (rep_mode == `CHC_QUAL_ALL) ? i_input_lines : 8'h00,
                                (rep_mode == `CHC_QUAL_IN) ? i_input_lines : o_output_lines};
          // a period ending in this very cycle must not be lost
          next_rep_pend = tick && rep_ms + 32'h00000001 >= period;
          next_tx_state = chc_pkg::CHC_TX_BUSY;
        end
      end
      chc_pkg::CHC_TX_BUSY: begin
        if (link.s2m_ready) begin
          next_tx_state = chc_pkg::CHC_TX_IDLE;
        end
      end
      default: begin
        next_tx_state = chc_pkg::CHC_TX_IDLE;
      end
    endcase

    next_output_lines = next_safe ? `CHC_SAFE_VALUE : next_out_value;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      booted <= 1'b0;
      ms_cnt <= 32'h00000000;
      hb_ms <= 32'h00000000;
      timeout <= `CHC_TIMEOUT_RST;
      period <= `CHC_PERIOD_RST;
      rep_mode <= `CHC_QUAL_ALL;
      rep_ms <= 32'h00000000;
      rep_pend <= 1'b0;
      out_value <= `CHC_PWRON_RST;
      pwr_stored <= `CHC_PWRON_RST;
      safe <= 1'b0;
      tx_state <= chc_pkg::CHC_TX_IDLE;
      tx_frame <= '0;
      o_output_lines <= `CHC_PWRON_RST;
      o_safe_mode <= 1'b0;
      o_nv_write <= 1'b0;
      o_nv_sel <= `CHC_NV_TIMEOUT;
      o_nv_data <= 32'h00000000;
    end else begin
      booted <= next_booted;
      ms_cnt <= next_ms_cnt;
      hb_ms <= next_hb_ms;
      timeout <= next_timeout;
      period <= next_period;
      rep_mode <= next_rep_mode;
      rep_ms <= next_rep_ms;
      rep_pend <= next_rep_pend;
      out_value <= next_out_value;
      pwr_stored <= next_pwr_stored;
      safe <= next_safe;
      tx_state <= next_tx_state;
      tx_frame <= next_tx_frame;
      o_output_lines <= next_output_lines;
      o_safe_mode <= next_safe;
      o_nv_write <= next_nv_write;
      o_nv_sel <= next_nv_sel;
      o_nv_data <= next_nv_data;
    end
  end
endmodule // chc_device
`default_nettype wire

// File: src/chc_host.sv
`timescale 1ns/1ns
`default_nettype none
`include "chc_cfg.svh"
module chc_host #(
  parameter int unsigned CYC_PER_MS = `CHC_MS_NS / `CHC_CLK_PERIOD_NS
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  chc_link_if.host link,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata
);
  logic hb_en;
  logic [31:0] hb_period;
  logic [31:0] cmd_hdr;
  logic [31:0] cmd_lo;
  logic [31:0] cmd_hi;
  logic cmd_pend;
  logic resp_valid;
  chc_pkg::chc_frame_s resp;
  logic [31:0] ms_cnt;
  logic [31:0] hb_ms;
  logic hb_pend;
  logic m2s_valid;
  chc_pkg::chc_frame_s m2s_frame;
  logic ready;

  logic next_hb_en;
  logic [31:0] next_hb_period;
  logic [31:0] next_cmd_hdr;
  logic [31:0] next_cmd_lo;
  logic [31:0] next_cmd_hi;
  logic next_cmd_pend;
  logic next_resp_valid;
  chc_pkg::chc_frame_s next_resp;
  logic [31:0] next_ms_cnt;
  logic [31:0] next_hb_ms;
  logic next_hb_pend;
  logic next_m2s_valid;
  chc_pkg::chc_frame_s next_m2s_frame;
  logic [31:0] next_rdata;
  logic tick;

  assign link.m2s_valid = m2s_valid;
  assign link.m2s_frame = m2s_frame;
  assign link.s2m_ready = ready;

  always_comb begin
    tick = (ms_cnt == 32'(CYC_PER_MS - 1));
    next_ms_cnt = tick ? 32'h00000000 : ms_cnt + 32'h00000001;
    next_hb_en = hb_en;
    next_hb_period = hb_period;
    next_cmd_hdr = cmd_hdr;
    next_cmd_lo = cmd_lo;
    next_cmd_hi = cmd_hi;
    next_cmd_pend = cmd_pend;
    next_resp_valid = resp_valid;
    next_resp = resp;
    next_hb_ms = hb_ms;
    next_hb_pend = hb_pend;
    next_m2s_valid = 1'b0;
    next_m2s_frame = m2s_frame;
    next_rdata = 32'h00000000;

    if (i_wr) begin
      case (i_addr)
        `CHC_REG_CTRL: next_hb_en = i_wdata[`CHC_CTRL_HB_EN_BIT];
        `CHC_REG_HB_PERIOD: next_hb_period = i_wdata;
        `CHC_REG_CMD_HDR: next_cmd_hdr = i_wdata;
        `CHC_REG_CMD_LO: next_cmd_lo = i_wdata;
        `CHC_REG_CMD_HI: next_cmd_hi = i_wdata;
        `CHC_REG_GO: next_cmd_pend = 1'b1;
        `CHC_REG_STATUS: begin
          if (i_wdata[`CHC_STAT_RESP_BIT]) begin
            next_resp_valid = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        `CHC_REG_CTRL: next_rdata = {31'h00000000, hb_en};
        `CHC_REG_HB_PERIOD: next_rdata = hb_period;
        `CHC_REG_CMD_HDR: next_rdata = cmd_hdr;
        `CHC_REG_CMD_LO: next_rdata = cmd_lo;
        `CHC_REG_CMD_HI: next_rdata = cmd_hi;
        `CHC_REG_STATUS: next_rdata = {30'h00000000, resp_valid, cmd_pend};
        `CHC_REG_RESP_HDR: next_rdata = {2'h0, resp.ack, resp.rtr, resp.dlc, resp.qual, resp.station, resp.func};
        `CHC_REG_RESP_LO: next_rdata = resp.data[31:0];
        `CHC_REG_RESP_HI: next_rdata = resp.data[63:32];
        default: next_rdata = 32'h00000000;
      endcase
    end

    // an answer is taken only while the previous one has been cleared through the status register; set wins over clear
    if (link.s2m_valid && ready) begin
      next_resp = link.s2m_frame;
      next_resp_valid = 1'b1;
    end

    if (!hb_en) begin
      next_hb_ms = 32'h00000000;
      next_hb_pend = 1'b0;
    end else if (tick) begin
      if (hb_ms + 32'h00000001 >= hb_period) begin
        next_hb_ms = 32'h00000000;
        next_hb_pend = 1'b1;
      end else begin
        next_hb_ms = hb_ms + 32'h00000001;
      end
    end

    // heartbeat first, so a busy command stream never starves supervision;
    // an idle cycle after every frame keeps each strobe a lone pulse
    if (hb_pend && !m2s_valid) begin
      next_m2s_valid = 1'b1;
      next_m2s_frame = '0;
      next_m2s_frame.func = `CHC_FUNC_HB;
      next_m2s_frame.station = `CHC_HOST_STATION;
      next_m2s_frame.qual = `CHC_QUAL_ALL;
      next_m2s_frame.dlc = `CHC_DLC_BYTE;
      next_m2s_frame.data = {56'h00000000000000, `CHC_HB_DATA};
      // a period ending in this very cycle must not be lost
      next_hb_pend = hb_en && tick && hb_ms + 32'h00000001 >= hb_period;
    end else if (cmd_pend && !m2s_valid) begin
      next_m2s_valid = 1'b1;
      next_m2s_frame.ack = cmd_hdr[`CHC_HDR_ACK_BIT];
      next_m2s_frame.func = cmd_hdr[`CHC_HDR_FUNC_LSB +: 8];
      next_m2s_frame.station = cmd_hdr[`CHC_HDR_STATION_LSB +: 8];
      next_m2s_frame.qual = cmd_hdr[`CHC_HDR_QUAL_LSB +: 8];
      next_m2s_frame.rtr = cmd_hdr[`CHC_HDR_RTR_BIT];
      next_m2s_frame.dlc = cmd_hdr[`CHC_HDR_DLC_LSB +: 4];
      next_m2s_frame.data = {cmd_hi, cmd_lo};
      next_cmd_pend = i_wr && i_addr == `CHC_REG_GO;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      hb_en <= 1'b0;
      hb_period <= `CHC_HB_PERIOD_RST;
      cmd_hdr <= 32'h00000000;
      cmd_lo <= 32'h00000000;
      cmd_hi <= 32'h00000000;
      cmd_pend <= 1'b0;
      resp_valid <= 1'b0;
      resp <= '0;
      ms_cnt <= 32'h00000000;
      hb_ms <= 32'h00000000;
      hb_pend <= 1'b0;
      m2s_valid <= 1'b0;
      m2s_frame <= '0;
      ready <= 1'b0;
      o_rdata <= 32'h00000000;
    end else begin
      hb_en <= next_hb_en;
      hb_period <= next_hb_period;
      cmd_hdr <= next_cmd_hdr;
      cmd_lo <= next_cmd_lo;
      cmd_hi <= next_cmd_hi;
      cmd_pend <= next_cmd_pend;
      resp_valid <= next_resp_valid;
      resp <= next_resp;
      ms_cnt <= next_ms_cnt;
      hb_ms <= next_hb_ms;
      hb_pend <= next_hb_pend;
      m2s_valid <= next_m2s_valid;
      m2s_frame <= next_m2s_frame;
      ready <= !next_resp_valid;
      o_rdata <= next_rdata;
    end
  end
endmodule // chc_host
`default_nettype wire

// File: tb/chc_link_sva.sv
`timescale 1ns/1ns
`default_nettype none
`include "chc_cfg.svh"
module chc_link_sva #(
  parameter logic [7:0] STATION = 8'h0A
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic m2s_valid,
  input wire chc_pkg::chc_frame_s m2s_frame,
  input wire logic s2m_valid,
  input wire logic s2m_ready,
  input wire chc_pkg::chc_frame_s s2m_frame
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  logic own;
  logic setw;
  // a command only counts when the device is idle, busy ones are dropped
  assign own = m2s_valid && !m2s_frame.ack && m2s_frame.station == STATION && !s2m_valid;
  assign setw = own && !m2s_frame.rtr && m2s_frame.dlc == `CHC_DLC_WORD;
  a_hold_answer: assert property (s2m_valid && !s2m_ready |=> s2m_valid && $stable(s2m_frame))
    else $error("device frame changed before accept");
  a_release_answer: assert property (s2m_valid && s2m_ready |=> !s2m_valid)
    else $error("device frame held after accept");
  a_host_pulse: assert property (m2s_valid |=> !m2s_valid)
    else $error("host strobe longer than one cycle");
  a_beat_format: assert property (m2s_valid && m2s_frame.func == `CHC_FUNC_HB |->
    m2s_frame.station == 8'hFE && m2s_frame.qual == 8'h00 && !m2s_frame.rtr && m2s_frame.dlc == 4'h1
    && m2s_frame.data[7:0] == 8'h00)
    else $error("bad heartbeat frame");
  a_timeout_echo: assert property (setw && m2s_frame.func == `CHC_FUNC_TIMEOUT && m2s_frame.qual == 8'h00
    && m2s_frame.data[31:0] >= 32'd10 |=> s2m_valid && s2m_frame.ack && s2m_frame.func == 8'h20
    && s2m_frame.data[31:0] == $past(m2s_frame.data[31:0]))
    else $error("timeout set not echoed");
  a_query_answer: assert property (own && m2s_frame.rtr && m2s_frame.dlc == 4'h4 && m2s_frame.qual == 8'h00
    && m2s_frame.func inside {8'h20, 8'h21} ##1 s2m_valid |-> s2m_frame.ack && !s2m_frame.rtr
    && s2m_frame.func == $past(m2s_frame.func))
    else $error("query answer wrong");
  a_short_refused: assert property (setw && m2s_frame.func inside {8'h20, 8'h21}
    && m2s_frame.data[31:0] inside {[32'd1:32'd9]} |=> !s2m_valid || s2m_frame.func == `CHC_FUNC_IO)
    else $error("short value answered");
  a_report_shape: assert property (s2m_valid && s2m_frame.func == `CHC_FUNC_IO |->
    (s2m_frame.qual == 8'h00 && s2m_frame.dlc == 4'h2) || (s2m_frame.qual inside {8'h01, 8'h02}
    && s2m_frame.dlc == 4'h1))
    else $error("report shape wrong");
  a_foreign_silent: assert property (m2s_valid && !m2s_frame.ack && !s2m_valid
    && m2s_frame.station != STATION && m2s_frame.station != 8'hFE |=> !s2m_valid || s2m_frame.func == `CHC_FUNC_IO)
    else $error("foreign station answered");
  a_pwron_echo: assert property (own && !m2s_frame.rtr && m2s_frame.func == `CHC_FUNC_PWRON
    && m2s_frame.qual == 8'h01 && m2s_frame.dlc == 4'h1 |=> s2m_valid && s2m_frame.ack
    && s2m_frame.data[7:0] == $past(m2s_frame.data[7:0]))
    else $error("power-on set not echoed");
  c_report: cover property (s2m_valid && s2m_ready && s2m_frame.func == `CHC_FUNC_IO);
  c_beat: cover property (m2s_valid && m2s_frame.func == `CHC_FUNC_HB);
  c_refused: cover property (setw && m2s_frame.data[31:0] == 32'd9);
endmodule // chc_link_sva
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "chc_cfg.svh"
module testbench;
  localparam logic [7:0] STN = 8'h0A;
  localparam logic [7:0] INL = 8'hA5;
  localparam logic [31:0] ACK = 32'h20000000;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h00000000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_out_cmd_valid = 1'b0;
  logic [7:0] i_out_cmd_value = 8'h00;
  logic [31:0] o_rdata, o_nv_data, nv_data;
  logic [7:0] o_output_lines;
  logic o_safe_mode, o_nv_write;
  logic [1:0] o_nv_sel, nv_sel;
  chc_pkg::chc_frame_s rep;
  int n_fail = 0;
  int checks = 0;
  int n_rep = 0;
  chc_link_if link();
  chc_host #(.CYC_PER_MS(10)) u_chc_host (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .link(link), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
  chc_device #(.CYC_PER_MS(10)) u_chc_device (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .link(link),
    .i_station_number(STN), .i_input_lines(INL), .i_out_cmd_valid(i_out_cmd_valid),
    .i_out_cmd_value(i_out_cmd_value), .i_nv_power_on_value(8'h5A), .o_output_lines(o_output_lines),
    .o_safe_mode(o_safe_mode), .o_nv_write(o_nv_write), .o_nv_sel(o_nv_sel), .o_nv_data(o_nv_data));
  chc_link_sva #(.STATION(STN)) u_chc_link_sva (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .m2s_valid(link.m2s_valid), .m2s_frame(link.m2s_frame), .s2m_valid(link.s2m_valid),
    .s2m_ready(link.s2m_ready), .s2m_frame(link.s2m_frame));
  initial begin
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  // nv strobe and report handshakes last one cycle, so latch them here
  always @(posedge i_sys_clk) begin
    if (o_nv_write === 1'b1) begin
      nv_sel <= o_nv_sel;
      nv_data <= o_nv_data;
    end
    if (link.s2m_valid === 1'b1 && link.s2m_ready === 1'b1 && link.s2m_frame.func === `CHC_FUNC_IO) begin
      rep <= link.s2m_frame;
      n_rep <= n_rep + 1;
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    @(posedge i_sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
    @(posedge i_sys_clk);
  endtask
  function automatic logic [31:0] mk(input logic [7:0] f, input logic [7:0] q, input logic [3:0] n,
                                     input logic r, input logic [7:0] s = STN);
    return {3'b000, r, n, q, s, f};
  endfunction
  // reports share the answer registers, so they are skipped while waiting
  task automatic cmd(input logic [31:0] h, input logic [31:0] v, input int lim, output logic [31:0] rh,
                     output logic [31:0] rl, output bit got);
    logic [31:0] st;
    wr(`CHC_REG_CMD_HDR, h);
    wr(`CHC_REG_CMD_LO, v);
    wr(`CHC_REG_CMD_HI, 32'h0);
    wr(`CHC_REG_GO, 32'h1);
    got = 1'b0;
    for (int k = 0; k < lim && !got; k++) begin
      rd(`CHC_REG_STATUS, st);
      if (st[`CHC_STAT_RESP_BIT] === 1'b1) begin
        rd(`CHC_REG_RESP_HDR, rh);
        rd(`CHC_REG_RESP_LO, rl);
        wr(`CHC_REG_STATUS, 32'h2);
        got = (rh[7:0] !== `CHC_FUNC_IO);
      end
    end
  endtask
  task automatic set_chk(input logic [31:0] h, input logic [31:0] v);
    logic [31:0] rh, rl;
    bit got;
    cmd(h, v, 200, rh, rl, got);
    chk("echo header", got ? rh : 32'h0, h | ACK);
    chk("echo data", rl, v);
  endtask
  task automatic query_chk(input logic [7:0] f, input logic [7:0] q, input logic [3:0] n, input logic [31:0] v);
    logic [31:0] rh, rl;
    bit got;
    cmd(mk(f, q, n, 1'b1), 32'h0, 200, rh, rl, got);
    chk("query header", got ? rh : 32'h0, mk(f, q, n, 1'b0) | ACK);
    chk("query data", (n == 4'h1) ? {24'h0, rl[7:0]} : rl, v);
  endtask
  task automatic drive_out(input logic [7:0] v);
    i_out_cmd_value <= v;
    i_out_cmd_valid <= 1'b1;
    @(posedge i_sys_clk);
    i_out_cmd_valid <= 1'b0;
    wait_cyc(3);
  endtask
  task automatic t_boot();
    wait_cyc(3);
    chk("power-on lines", {24'h0, o_output_lines}, 32'h5A);
    query_chk(`CHC_FUNC_TIMEOUT, 8'h00, 4'h4, 32'd100);
    query_chk(`CHC_FUNC_PERIOD, 8'h00, 4'h4, 32'd1000);
    set_chk(mk(`CHC_FUNC_PWRON, 8'h01, 4'h1, 1'b0), 32'h07);
    chk("nv select", {30'h0, nv_sel}, 32'h2);
    chk("nv data", {24'h0, nv_data[7:0]}, 32'h07);
    chk("lines kept", {24'h0, o_output_lines}, 32'h5A);
    query_chk(`CHC_FUNC_PWRON, 8'h01, 4'h1, 32'h07);
  endtask
  task automatic t_timeout();
    set_chk(mk(`CHC_FUNC_TIMEOUT, 8'h00, 4'h4, 1'b0), 32'h000003E8);
    chk("nv select", {30'h0, nv_sel}, 32'h0);
    chk("nv data", nv_data, 32'h000003E8);
    query_chk(`CHC_FUNC_TIMEOUT, 8'h00, 4'h4, 32'h000003E8);
    set_chk(mk(`CHC_FUNC_TIMEOUT, 8'h00, 4'h4, 1'b0), 32'hFFFFFFFF);
    query_chk(`CHC_FUNC_TIMEOUT, 8'h00, 4'h4, 32'hFFFFFFFF);
  endtask
  task automatic t_refuse();
    logic [31:0] hs [6];
    logic [31:0] vs [6];
    logic [31:0] rh, rl;
    bit got;
    hs = '{mk(8'h20, 8'h00, 4'h4, 1'b0), mk(8'h20, 8'h01, 4'h4, 1'b0), mk(8'h20, 8'h00, 4'h4, 1'b0, 8'h0B),
           mk(8'h21, 8'h03, 4'h4, 1'b0), mk(8'h21, 8'h00, 4'h4, 1'b0), mk(8'h60, 8'h00, 4'h1, 1'b0)};
    vs = '{32'd9, 32'd1000, 32'd1000, 32'd1000, 32'd9, 32'h07};
    foreach (hs[i]) begin
      cmd(hs[i], vs[i], 30, rh, rl, got);
      chk("refused", {31'h0, got}, 32'h0);
    end
    query_chk(`CHC_FUNC_TIMEOUT, 8'h00, 4'h4, 32'hFFFFFFFF);
  endtask
  task automatic t_safe();
    wr(`CHC_REG_CTRL, 32'h0);
    drive_out(8'h3C);
    chk("lines follow", {24'h0, o_output_lines}, 32'h3C);
    set_chk(mk(`CHC_FUNC_TIMEOUT, 8'h00, 4'h4, 1'b0), 32'd10);
    wait_cyc(70);
    chk("safe early", {31'h0, o_safe_mode}, 32'h0);
    wait_cyc(60);
    chk("safe entered", {31'h0, o_safe_mode}, 32'h1);
    chk("safe lines", {24'h0, o_output_lines}, 32'h0);
    drive_out(8'hC3);
    chk("lines locked", {24'h0, o_output_lines}, 32'h0);
    wr(`CHC_REG_HB_PERIOD, 32'd5);
    wr(`CHC_REG_CTRL, 32'h1);
    wait_cyc(90);
    chk("safe left", {31'h0, o_safe_mode}, 32'h0);
    drive_out(8'hC3);
    chk("lines free", {24'h0, o_output_lines}, 32'hC3);
  endtask
  task automatic t_report();
    int n0;
    logic [15:0] ex;
    for (int m = 0; m < 3; m++) begin
      set_chk(mk(`CHC_FUNC_PERIOD, m[7:0], 4'h4, 1'b0), 32'd10);
      chk("nv select", {30'h0, nv_sel}, 32'h1);
      n0 = n_rep;
      for (int k = 0; k < 200 && n_rep < n0 + 2; k++) begin
        wr(`CHC_REG_STATUS, 32'h2);
      end
      ex = (m == 0) ? {INL, 8'hC3} : (m == 1) ? 16'h00C3 : {8'h00, INL};
      chk("report count", {31'h0, n_rep >= n0 + 2}, 32'h1);
      chk("report frame", {rep.qual, 4'h0, rep.dlc, (m == 0) ? rep.data[15:0] : {8'h00, rep.data[7:0]}},
          {m[7:0], 4'h0, (m == 0) ? 4'h2 : 4'h1, ex});
    end
    set_chk(mk(`CHC_FUNC_PERIOD, 8'h00, 4'h4, 1'b0), 32'h0);
    repeat (10) wr(`CHC_REG_STATUS, 32'h2);
    n0 = n_rep;
    repeat (150) wr(`CHC_REG_STATUS, 32'h2);
    chk("reports stopped", 32'(n_rep - n0), 32'h0);
  endtask
  initial begin
    repeat (12) @(posedge i_sys_clk);
    chk("reset lines", {24'h0, o_output_lines}, 32'h0);
    i_reset <= 1'b0;
    t_boot();
    t_timeout();
    t_refuse();
    t_safe();
    t_report();
    final_report();
  end
  initial begin
    repeat (40000) @(posedge i_sys_clk);
    n_fail++;
    final_report();
  end
endmodule // testbench
`default_nettype wire
